// *** rtl/rds_pkg.sv ***
// Package: constants and types for the reset-domain strap defaults block
package rds_pkg;

  // --------------------------------------------------------------
  // Register file shape
  // --------------------------------------------------------------
  localparam int unsigned REG_COUNT = 28;
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 8;

  // Group boundaries by register index
  localparam logic [ADDR_W-1:0] IDX_B_LAST = 5'h0_00F;
  localparam logic [ADDR_W-1:0] IDX_UNGROUPED = 5'h0_00E;
  localparam logic [ADDR_W-1:0] IDX_C_FIRST = 5'h0_010;
  localparam logic [ADDR_W-1:0] IDX_C_LAST = 5'h0_01B;

  // Registers holding the default-code fields
  localparam logic [ADDR_W-1:0] IDX_VOLT = 5'h0_002;
  localparam logic [ADDR_W-1:0] IDX_STBY = 5'h0_005;
  localparam logic [ADDR_W-1:0] IDX_ONDLY_A = 5'h0_009;
  localparam logic [ADDR_W-1:0] IDX_ONDLY_B = 5'h0_00A;
  localparam logic [ADDR_W-1:0] IDX_OFFDLY_A = 5'h0_00B;
  localparam logic [ADDR_W-1:0] IDX_OFFDLY_B = 5'h0_00C;

  // Plain reset value for every other register
  localparam logic [DATA_W-1:0] PLAIN_RESET = 8'h0_0;
  // Class after reset before any latch
  localparam logic [2:0] CLASS_RESET = 3'h0_5;

  // --------------------------------------------------------------
  // Default codes
  // --------------------------------------------------------------
  localparam logic [3:0] CORE_V_A = 4'h0_D;
  localparam logic [3:0] CORE_V_4 = 4'h0_8;
  localparam logic [3:0] CORE_V_3 = 4'h0_F;
  localparam logic [3:0] MEM_V = 4'h0_9;
  localparam logic [2:0] STBY_V_REF = 3'h0_7;
  localparam logic [2:0] STBY_V_2 = 3'h0_5;
  localparam logic [2:0] STBY_V_45 = 3'h0_3;
  localparam logic [3:0] CORE_ON = 4'h0_7;
  localparam logic [3:0] OTHER_ON = 4'h0_9;
  localparam logic [3:0] BB_ON_1 = 4'h0_B;
  localparam logic [3:0] CORE_OFF = 4'h0_A;
  localparam logic [3:0] OTHER_OFF = 4'h0_0;

  // Strap class codes from the comparator stage
  typedef enum logic [2:0] {
    SEQ_RSVD, SEQ_1, SEQ_2, SEQ_3, SEQ_4, SEQ_5
  } rds_class_t;

  // Resolved default codes travel together
  typedef struct packed {
    logic [3:0] coreBuckVoltageCode;
    logic [3:0] memoryBuckVoltageCode;
    logic [2:0] standbyBuckVoltageCode;
    logic [3:0] buckboostPowerOnDelay;
    logic [3:0] corePowerOnDelay;
    logic [3:0] memoryPowerOnDelay;
    logic [3:0] standbyPowerOnDelay;
    logic [3:0] buckboostPowerOffDelay;
    logic [3:0] corePowerOffDelay;
    logic [3:0] memoryPowerOffDelay;
    logic [3:0] standbyPowerOffDelay;
  } rds_defaults_t;

  // Register bus request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } rds_bus_req_t;

endpackage

// *** rtl/rds_reg_mem.sv ***
// Register memory with three reset groups and registered read data
`timescale 1ns/100ps
module rds_reg_mem
  import rds_pkg::*;
#(
  parameter int unsigned DEPTH = REG_COUNT
) (
  input wire logic refClk,
  input wire logic arstN,
  input wire logic loadA,
  input wire logic loadB,
  input wire logic loadC,
  input wire logic [DATA_W*REG_COUNT-1:0] defaults,
  input wire logic [REG_COUNT-1:0] inGroupA,
  input wire logic [REG_COUNT-1:0] inGroupB,
  input wire logic [REG_COUNT-1:0] inGroupC,
  input wire logic wrEn,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic rdEn,
  output logic [DATA_W-1:0] rdata,
  output logic [DATA_W*REG_COUNT-1:0] regFlat
);

  // Refuse a depth that the group masks cannot describe
  if (DEPTH != REG_COUNT) begin : gBadDepth
    $error("rds_reg_mem: DEPTH must equal REG_COUNT");
  end

  // --------------------------------------------------------------
  // Storage, one generate entry per register
  // --------------------------------------------------------------
  logic [DATA_W-1:0] mem [DEPTH];

  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++) begin : gReg
      wire logic reload = (loadA & inGroupA[gi]) | (loadB & inGroupB[gi]) |
                          (loadC & inGroupC[gi]);
      wire logic hit = wrEn && (addr == ADDR_W'(gi));
      // Reload outranks a host write in the same cycle
      always_ff @(posedge refClk or negedge arstN) begin
        if (!arstN) begin
          mem[gi] <= PLAIN_RESET;
        end else if (reload) begin
          mem[gi] <= defaults[gi*DATA_W +: DATA_W];
        end else if (hit) begin
          mem[gi] <= wdata;
        end
      end
      assign regFlat[gi*DATA_W +: DATA_W] = mem[gi];
    end
  endgenerate

  // Read data from a flop; unmapped index reads zero
  wire logic inRange = (32'(addr) < DEPTH);
  always_ff @(posedge refClk or negedge arstN) begin
    if (!arstN) begin
      rdata <= PLAIN_RESET;
    end else if (rdEn) begin
      rdata <= inRange ? mem[addr] : PLAIN_RESET;
    end else begin
      rdata <= PLAIN_RESET;
    end
  end

endmodule // rds_reg_mem

// *** rtl/rds_strap_defaults.sv ***
// Top: reset domains, strap latch and default loading for control regs
// Summary of operation
// (R01) Group A registers reload defaults while the enable pin is low.
// (R02) Indices 0-13 and 15 reload defaults while reset input is low.
// (R03) Indices 16-27 reload only on the clock-keeping block's own reset.
// (R04) Buck 3/4/10 voltage defaults: core and standby follow the latched strap class; memory code is fixed.
// (R05) Buck-boost power-on delay default follows the strap class; all other on and off delays are fixed.
// (R06) Strap class latched once when reset input rises, then held.
// (R07) Standby code 111 for classes 1,3; 101 class 2; 011 classes 4,5.
// (R08) Strap arrives pre-decoded; reserved class 0 treated as class 5.
//
// The register addresses and the address-and-strobe port were decided locally.
`timescale 1ns/100ps
module rds_strap_defaults
  import rds_pkg::*;
#(
  parameter logic [REG_COUNT-1:0] GROUP_A_MASK = '0
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic enablePin,
  input wire logic resetPinN,
  input wire logic clockKeepResetN,
  input wire logic [2:0] sequenceSelectStrap,
  input wire rds_pkg::rds_bus_req_t busReq,
  output logic [DATA_W-1:0] rdata,
  output logic [2:0] latchedClass,
  output rds_pkg::rds_defaults_t activeDefaults,
  output logic [DATA_W*REG_COUNT-1:0] regFlat
);
  import rds_pkg::*;

  // --------------------------------------------------------------
  // Pin synchronisers, two flops before any logic
  // --------------------------------------------------------------
  logic [2:0] syncA;
  logic [2:0] syncB;
  logic [2:0] strapA;
  logic [2:0] strapB;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      syncA <= 3'h0;
      syncB <= 3'h0;
      strapA <= CLASS_RESET;
      strapB <= CLASS_RESET;
    end else begin
      syncA <= {enablePin, resetPinN, clockKeepResetN};
      syncB <= syncA;
      strapA <= sequenceSelectStrap;
      strapB <= strapA;
    end
  end
  wire logic enSync = syncB[2];
  wire logic rstSyncN = syncB[1];
  wire logic ckRstSyncN = syncB[0];

  // --------------------------------------------------------------
  // Reset-pin edge detect and strap latch
  // --------------------------------------------------------------
  logic rstPrevN;
  logic rstRiseD;
  logic [2:0] strapClass;
  wire logic rstRise = rstSyncN & ~rstPrevN;
  // Latching only on the rise keeps later strap wobble harmless
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rstPrevN <= 1'b0;
      rstRiseD <= 1'b0;
      strapClass <= CLASS_RESET;
    end else begin
      rstPrevN <= rstSyncN;
      rstRiseD <= rstRise;
      if (rstRise) begin
        strapClass <= strapB; // see (R06)
      end
    end
  end
  assign latchedClass = strapClass;

  // --------------------------------------------------------------
  // Strap class to default codes
  // --------------------------------------------------------------
  // Reserved and unknown codes fall back to class 5
  wire logic is1 = (strapClass == SEQ_1);
  wire logic is2 = (strapClass == SEQ_2);
  wire logic is3 = (strapClass == SEQ_3);
  wire logic is4 = (strapClass == SEQ_4); // see (R08)
  rds_defaults_t dflt;
  assign dflt.coreBuckVoltageCode = is4 ? CORE_V_4 :
                                    is3 ? CORE_V_3 : CORE_V_A; // see (R04)
  assign dflt.memoryBuckVoltageCode = MEM_V; // see (R04)
  assign dflt.standbyBuckVoltageCode = (is1 | is3) ? STBY_V_REF :
                                       is2 ? STBY_V_2 : STBY_V_45; // see (R07)
  assign dflt.buckboostPowerOnDelay = is1 ? BB_ON_1 : OTHER_ON; // see (R05)
  assign dflt.corePowerOnDelay = CORE_ON; // see (R05)
  assign dflt.memoryPowerOnDelay = OTHER_ON;
  assign dflt.standbyPowerOnDelay = OTHER_ON;
  assign dflt.buckboostPowerOffDelay = OTHER_OFF;
  assign dflt.corePowerOffDelay = CORE_OFF; // see (R05)
  assign dflt.memoryPowerOffDelay = OTHER_OFF;
  assign dflt.standbyPowerOffDelay = OTHER_OFF;
  assign activeDefaults = dflt;

  // Default image per register index; channel 3/2 in high nibbles
  logic [DATA_W*REG_COUNT-1:0] dImage;
  always_comb begin
    dImage = '0;
    dImage[IDX_VOLT*DATA_W +: DATA_W] =
      {dflt.coreBuckVoltageCode, dflt.memoryBuckVoltageCode};
    dImage[IDX_STBY*DATA_W +: DATA_W] = {5'h0_0, dflt.standbyBuckVoltageCode};
    dImage[IDX_ONDLY_A*DATA_W +: DATA_W] =
      {dflt.corePowerOnDelay, dflt.buckboostPowerOnDelay};
    dImage[IDX_ONDLY_B*DATA_W +: DATA_W] =
      {dflt.standbyPowerOnDelay, dflt.memoryPowerOnDelay};
    dImage[IDX_OFFDLY_A*DATA_W +: DATA_W] =
      {dflt.corePowerOffDelay, dflt.buckboostPowerOffDelay};
    dImage[IDX_OFFDLY_B*DATA_W +: DATA_W] =
      {dflt.standbyPowerOffDelay, dflt.memoryPowerOffDelay};
  end

  // --------------------------------------------------------------
  // Reset group membership
  // --------------------------------------------------------------
  logic [REG_COUNT-1:0] grpB;
  logic [REG_COUNT-1:0] grpC;
  always_comb begin
    for (int i = 0; i < REG_COUNT; i++) begin
      grpB[i] = (i <= int'(IDX_B_LAST)) && (i != int'(IDX_UNGROUPED)); // see (R02)
      grpC[i] = (i >= int'(IDX_C_FIRST)) && (i <= int'(IDX_C_LAST)); // see (R03)
    end
  end
  // Loads are levels: registers sit at defaults while held in reset
  wire logic loadA = ~enSync; // see (R01)
  // Reload one edge after the latch, when the image shows the new class
  wire logic loadB = ~rstSyncN | rstRiseD; // see (R02)
  wire logic loadC = ~ckRstSyncN; // see (R03)

  // The delayed rise pulse makes the fresh class reach the registers
  rds_reg_mem #(
    .DEPTH(REG_COUNT)
  ) uMem (
    .refClk(ref_clk),
    .arstN(arst_n),
    .loadA(loadA),
    .loadB(loadB),
    .loadC(loadC),
    .defaults(dImage),
    .inGroupA(GROUP_A_MASK),
    .inGroupB(grpB),
    .inGroupC(grpC),
    .wrEn(busReq.wr),
    .addr(busReq.addr),
    .wdata(busReq.wdata),
    .rdEn(busReq.rd),
    .rdata(rdata),
    .regFlat(regFlat)
  );

endmodule // rds_strap_defaults

// *** tb/rds_strap_defaults_sva.sv ***
// Checker: strap defaults and reset-group reloads at the top ports
`timescale 1ns/100ps
module rds_strap_defaults_sva
  import rds_pkg::*;
#(
  parameter logic [REG_COUNT-1:0] GROUP_A_MASK = '0
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic enablePin,
  input wire logic resetPinN,
  input wire logic clockKeepResetN,
  input wire logic [2:0] sequenceSelectStrap,
  input wire rds_pkg::rds_bus_req_t busReq,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic [2:0] latchedClass,
  input wire rds_pkg::rds_defaults_t activeDefaults,
  input wire logic [DATA_W*REG_COUNT-1:0] regFlat
);
  // Reserved and unused codes fold onto the floating class
  wire logic [2:0] cls = (latchedClass == 3'h0 || latchedClass > 3'h5) ?
    3'h5 : latchedClass;
  logic [2:0] up;
  // Age since reset: the first latch after release needs no pin edge
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) up <= 3'h0;
    else if (up != 3'h7) up <= up + 3'h1;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  a_core_volt: assert property (
    activeDefaults.coreBuckVoltageCode ==
    (cls == 3'h4 ? 4'h8 : cls == 3'h3 ? 4'hF : 4'hD))
    else $error("core code");
  a_mem_volt: assert property (
    activeDefaults.memoryBuckVoltageCode == 4'h9) else $error("memory code");
  a_stby_volt: assert property (
    activeDefaults.standbyBuckVoltageCode == (cls == 3'h2 ? 3'h5 :
    (cls == 3'h1 || cls == 3'h3) ? 3'h7 : 3'h3)) else $error("standby code");
  a_on_delay: assert property (
    {activeDefaults.buckboostPowerOnDelay,
    activeDefaults.corePowerOnDelay, activeDefaults.memoryPowerOnDelay,
    activeDefaults.standbyPowerOnDelay} == {(cls == 3'h1 ? 4'hB : 4'h9),
    12'h799}) else $error("on delay codes");
  a_off_delay: assert property (
    {activeDefaults.buckboostPowerOffDelay,
    activeDefaults.corePowerOffDelay, activeDefaults.memoryPowerOffDelay,
    activeDefaults.standbyPowerOffDelay} == 16'h0A00)
    else $error("off delays");
  a_class_hold: assert property (
    up == 3'h7 && !$stable(latchedClass) |->
    !$past(resetPinN, 2) || !$past(resetPinN, 3) || !$past(resetPinN, 4) ||
    !$past(resetPinN, 5)) else $error("class moved without reset rise");
  a_grpb_load: assert property (
    !resetPinN [*5] |-> regFlat[31:24] == 8'h00
    && regFlat[23:16] == {activeDefaults.coreBuckVoltageCode,
    activeDefaults.memoryBuckVoltageCode}) else $error("group B not reloaded");
  a_grpc_load: assert property (
    !clockKeepResetN [*5] |->
    regFlat[167:160] == 8'h00) else $error("group C not cleared");
  a_grpa_load: assert property (
    (GROUP_A_MASK[1] && !enablePin) [*5] |->
    regFlat[15:8] == 8'h00) else $error("group A not reloaded");
endmodule // rds_strap_defaults_sva

bind rds_strap_defaults rds_strap_defaults_sva #(.GROUP_A_MASK(GROUP_A_MASK))
  u_rds_strap_defaults_sva (.ref_clk, .arst_n, .enablePin, .resetPinN,
  .clockKeepResetN, .sequenceSelectStrap, .busReq, .rdata, .latchedClass,
  .activeDefaults, .regFlat);

// *** tb/rds_host_model.sv ***
// Host model that owns the enable, reset and strap pins
`timescale 1ns/100ps
module rds_host_model (
  input wire logic refClk,
  output logic enablePin,
  output logic resetPinN,
  output logic clockKeepResetN,
  output logic [2:0] sequenceSelectStrap
);
  // Pins rest inactive; strap starts on the floating class
  task automatic rest();
    enablePin <= 1'h1;
    resetPinN <= 1'h1;
    clockKeepResetN <= 1'h1;
    sequenceSelectStrap <= 3'h5;
  endtask
  // Hold one pin low past the synchronisers, then give them time to settle
  task automatic pulse(input int pin);
    @(posedge refClk);
    case (pin)
      0: enablePin <= 1'h0;
      1: resetPinN <= 1'h0;
      default: clockKeepResetN <= 1'h0;
    endcase
    repeat (5) @(posedge refClk);
    {enablePin, resetPinN, clockKeepResetN} <= 3'h7;
    repeat (6) @(posedge refClk);
  endtask
  task automatic set_strap(input logic [2:0] cls);
    @(posedge refClk);
    sequenceSelectStrap <= cls;
  endtask
endmodule // rds_host_model

// *** tb/tb_rds_strap_defaults.sv ***
// Self-checking bench for strap defaults and reset groups
`timescale 1ns/100ps
`define CHK(a, b) begin nTests++; if ((a) !== (b)) begin badCount++; \
  $display("MISMATCH %0t got %h want %h", $time, a, b); end end
module tb_rds_strap_defaults;
  import rds_pkg::*;
  logic ref_clk = 1'h0;
  logic arst_n = 1'h0;
  rds_bus_req_t busReq = '0;
  logic [DATA_W-1:0] rdata;
  logic [2:0] latchedClass;
  rds_defaults_t activeDefaults;
  logic [DATA_W*REG_COUNT-1:0] regFlat;
  logic enablePin, resetPinN, clockKeepResetN;
  logic [2:0] sequenceSelectStrap;
  int badCount = 0;
  int nTests = 0;
  int cycles = 0;
  logic [4:0] idxList [6] = '{5'h02, 5'h05, 5'h09, 5'h0A, 5'h0B, 5'h0C};
  rds_host_model u_rds_host_model (.refClk(ref_clk), .enablePin,
    .resetPinN, .clockKeepResetN, .sequenceSelectStrap);
  rds_strap_defaults #(.GROUP_A_MASK(28'h000_0002)) u_rds_strap_defaults (
    .ref_clk, .arst_n, .enablePin, .resetPinN, .clockKeepResetN,
    .sequenceSelectStrap, .busReq, .rdata, .latchedClass, .activeDefaults,
    .regFlat);
  initial forever #25 ref_clk = ~ref_clk;
  // Expected register contents per class; reserved class acts as floating
  function automatic logic [7:0] expReg(input int c, input int i);
    if (c == 0) c = 5;
    case (i)
      2: return {(c == 4 ? 4'h8 : c == 3 ? 4'hF : 4'hD), 4'h9};
      5: return {5'h00, (c == 2 ? 3'h5 : (c == 1 || c == 3) ? 3'h7 : 3'h3)};
      9: return {4'h7, (c == 1 ? 4'hB : 4'h9)};
      10: return 8'h99;
      11: return 8'hA0;
      default: return 8'h00;
    endcase
  endfunction
  task automatic wrReg(input logic [4:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    busReq <= '{wr: 1'h1, rd: 1'h0, addr: a, wdata: d};
    @(posedge ref_clk);
    busReq.wr <= 1'h0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rdChk(input logic [4:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    busReq <= '{wr: 1'h0, rd: 1'h1, addr: a, wdata: 8'h00};
    @(posedge ref_clk);
    busReq.rd <= 1'h0;
    #1 `CHK(rdata, e)
  endtask
  task automatic final_report();
    $display("Checks %0d mismatches %0d", nTests, badCount);
    if (badCount == 0 && nTests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Hang guard, far above the few hundred cycles the sequence needs
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      badCount++;
      final_report();
    end
  end
  initial begin
    u_rds_host_model.rest();
    repeat (12) @(posedge ref_clk);
    arst_n <= 1'h1;
    repeat (6) @(posedge ref_clk);
    for (int c = 0; c < 6; c++) begin
      u_rds_host_model.set_strap(3'(c));
      u_rds_host_model.pulse(1);
      `CHK(latchedClass, 3'(c))
      foreach (idxList[i]) begin
        rdChk(idxList[i], expReg(c, idxList[i]));
      end
    end
    u_rds_host_model.set_strap(3'h1);
    repeat (6) @(posedge ref_clk);
    `CHK(latchedClass, 3'h5)
    rdChk(5'h05, expReg(5, 5));
    wrReg(5'h03, 8'hAA);
    wrReg(5'h14, 8'h55);
    wrReg(5'h0E, 8'h3C);
    u_rds_host_model.pulse(1);
    rdChk(5'h03, 8'h00);
    rdChk(5'h14, 8'h55);
    rdChk(5'h0E, 8'h3C);
    wrReg(5'h01, 8'h11);
    wrReg(5'h03, 8'hAA);
    u_rds_host_model.pulse(0);
    rdChk(5'h01, 8'h00);
    rdChk(5'h03, 8'hAA);
    u_rds_host_model.pulse(2);
    rdChk(5'h14, 8'h00);
    rdChk(5'h03, 8'hAA);
    wrReg(5'h1E, 8'hFF);
    rdChk(5'h1E, 8'h00);
    // Mid-run power-on reset: the standing strap must be latched again
    @(posedge ref_clk);
    arst_n <= 1'h0;
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'h1;
    repeat (6) @(posedge ref_clk);
    `CHK(latchedClass, 3'h1)
    rdChk(5'h05, expReg(1, 5));
    rdChk(5'h0E, 8'h00);
    final_report();
  end
endmodule // tb_rds_strap_defaults
